// [dv/ospt_far_end.sv]
// Far-side model: trigger source on the input pin and load measuring the pulse pin.
`timescale 1ns/100ps
module ospt_far_end (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic fire,
    input wire logic pulse_output_pin,
    output logic trigger_input_pin,
    output logic [31:0] hi_len,
    output logic [31:0] per_len,
    output logic [31:0] rise_cnt
);
    logic [3:0] hold_q;
    logic [31:0] hi_q;
    logic [31:0] per_q;
    logic last_q;
    logic rise;
    // The trigger is held six cycles so the two-stage synchroniser cannot miss it.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_q <= 4'h0;
        end else if (fire) begin
            hold_q <= 4'h6;
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end
    end
    assign trigger_input_pin = (hold_q != 4'h0);
    assign rise = pulse_output_pin && !last_q;
    // The load times each high phase and each rising-to-rising period in core cycles.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            last_q <= 1'b0;
            hi_q <= 32'h0;
            per_q <= 32'h0;
            hi_len <= 32'h0;
            per_len <= 32'h0;
            rise_cnt <= 32'h0;
        end else begin
            last_q <= pulse_output_pin;
            per_q <= rise ? 32'h1 : per_q + 32'h1;
            hi_q <= pulse_output_pin ? hi_q + 32'h1 : 32'h0;
            if (rise) begin
                rise_cnt <= rise_cnt + 32'h1;
                per_len <= per_q;
            end
            if (!pulse_output_pin && last_q) begin
                hi_len <= hi_q;
            end
        end
    end
endmodule // ospt_far_end

// [dv/tb.sv]
// Self-checking testbench for the one-shot and PWM timer channel.
`timescale 1ns/100ps
module tb;
    import ospt_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sub_clk_pin = 1'b0;
    ospt_src_t src_sel = OSPT_SRC_F1;
    logic pwm_mode = 1'b0;
    logic pwm_8bit = 1'b0;
    logic trig_pin_en = 1'b0;
    logic ext_trig_en = 1'b0;
    logic ovf_trig_en = 1'b0;
    logic assoc_overflow = 1'b0;
    logic out_pin_en = 1'b1;
    logic port_out_val = 1'b0;
    logic count_start = 1'b0;
    logic oneshot_start = 1'b0;
    logic wr_en = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic fire = 1'b0;
    logic trigger_input_pin, port_in_val, pulse_output_pin, irq, running;
    logic [15:0] rd_data;
    logic [31:0] hi_len, per_len, rise_cnt, base, rb;
    logic [31:0] irq_cnt = 32'h0;
    int error_cnt = 0;
    int checks_done = 0;
    int div [3] = '{1, 8, 32};

    // ------------------------------------------------------------------
    // Clocks, design and far side
    // ------------------------------------------------------------------
    // The subclock period of 10.4 core cycles keeps it unrelated in phase.
    always #12.5 core_clk = ~core_clk;
    always #130 sub_clk_pin = ~sub_clk_pin;
    always @(posedge core_clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 32'h1;

    ospt_timer i_ospt_timer (.core_clk(core_clk), .sys_rst(sys_rst), .sub_clk_pin(sub_clk_pin),
        .trigger_input_pin(trigger_input_pin), .src_sel(src_sel), .pwm_mode(pwm_mode),
        .pwm_8bit(pwm_8bit), .trig_pin_en(trig_pin_en), .ext_trig_en(ext_trig_en),
        .ovf_trig_en(ovf_trig_en), .assoc_overflow(assoc_overflow), .out_pin_en(out_pin_en),
        .port_out_val(port_out_val), .count_start(count_start), .oneshot_start(oneshot_start),
        .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .port_in_val(port_in_val),
        .pulse_output_pin(pulse_output_pin), .irq(irq), .running(running));
    ospt_far_end i_ospt_far_end (.core_clk(core_clk), .sys_rst(sys_rst), .fire(fire),
        .pulse_output_pin(pulse_output_pin), .trigger_input_pin(trigger_input_pin),
        .hi_len(hi_len), .per_len(per_len), .rise_cnt(rise_cnt));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // All drivers start at a falling edge and leave at one.
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [15:0] v);
        wr_en = 1'b1;
        wr_data = v;
        cyc(1);
        wr_en = 1'b0;
    endtask
    // A wait that runs out of cycles ends the run as a mismatch.
    task automatic wait_run(input logic lvl, input int bound);
        for (int i = 0; i < bound && running !== lvl; i++) cyc(1);
        if (running !== lvl) begin
            chk("running wait", {31'h0, lvl}, {31'h0, running});
            stop_test();
        end
    endtask
    task automatic wait_rise(input logic [31:0] target, input int bound);
        for (int i = 0; i < bound && rise_cnt < target; i++) cyc(1);
        if (rise_cnt < target) begin
            chk("rise wait", target, rise_cnt);
            stop_test();
        end
    endtask
    task automatic go();
        base = irq_cnt;
        oneshot_start = 1'b1;
        cyc(1);
        oneshot_start = 1'b0;
        wait_run(1'b1, 10);
    endtask
    task automatic finish();
        wait_run(1'b0, 3000);
        cyc(2);
        chk("oneshot irq", 32'h1, irq_cnt - base);
    endtask
    task automatic pwm_run(input logic wide8, input logic [15:0] v);
        count_start = 1'b0;
        pwm_mode = 1'b1;
        pwm_8bit = wide8;
        cyc(2);
        wr(v);
        base = irq_cnt;
        rb = rise_cnt;
        count_start = 1'b1;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(3);
        sys_rst = 1'b0;
        cyc(3);
        chk("running", 32'h0, {31'h0, running});
        chk("pulse", 32'h0, {31'h0, pulse_output_pin});
        chk("rd known", 32'h1, {31'h0, ^rd_data !== 1'bx});
        count_start = 1'b1;
        // One shot of three periods per source; the divider runs free, so the first period is partial.
        for (int k = 0; k < 3; k++) begin
            src_sel = ospt_src_t'(k);
            wr(16'h0003);
            go();
            finish();
            chk("shot width", 32'h1, {31'h0, hi_len > 2 * div[k] && hi_len <= 3 * div[k]});
        end
        src_sel = OSPT_SRC_FC32;
        wr(16'h0003);
        go();
        finish();
        chk("subclk width", 32'h1, {31'h0, hi_len > 660 && hi_len < 1005});
        src_sel = OSPT_SRC_F1;
        // A write while counting reaches the counter only at the next reload.
        wr(16'h0028);
        go();
        cyc(5);
        wr(16'h0007);
        finish();
        chk("reload hold", 32'd40, hi_len);
        go();
        finish();
        chk("reload next", 32'd7, hi_len);
        // A retrigger mid-count restarts the countdown.
        ovf_trig_en = 1'b1;
        wr(16'h001e);
        go();
        cyc(10);
        assoc_overflow = 1'b1;
        cyc(1);
        assoc_overflow = 1'b0;
        finish();
        chk("retrigger", 32'h1, {31'h0, hi_len > 38 && hi_len < 44});
        // Clearing the start flag stops at once with no interrupt.
        wr(16'h00c8);
        go();
        cyc(20);
        base = irq_cnt;
        count_start = 1'b0;
        cyc(2);
        chk("stop running", 32'h0, {31'h0, running});
        cyc(250);
        chk("stop irq", 32'h0, irq_cnt - base);
        count_start = 1'b1;
        // Pin as trigger, then as a plain port.
        trig_pin_en = 1'b1;
        ext_trig_en = 1'b1;
        wr(16'h0005);
        base = irq_cnt;
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        wait_run(1'b1, 10);
        finish();
        chk("pin shot", 32'd5, hi_len);
        trig_pin_en = 1'b0;
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        cyc(4);
        chk("port in", 32'h1, {31'h0, port_in_val});
        cyc(6);
        chk("port no trig", 32'h0, {31'h0, running});
        out_pin_en = 1'b0;
        port_out_val = 1'b1;
        cyc(3);
        chk("port out hi", 32'h1, {31'h0, pulse_output_pin});
        port_out_val = 1'b0;
        cyc(3);
        chk("port out lo", 32'h0, {31'h0, pulse_output_pin});
        out_pin_en = 1'b1;
        // 8-bit PWM, n=3 and m=1, with an ignored trigger mid-period.
        pwm_run(1'b1, 16'h0301);
        wait_rise(rb + 32'h1, 20);
        cyc(100);
        assoc_overflow = 1'b1;
        cyc(1);
        assoc_overflow = 1'b0;
        wait_rise(rb + 32'h2, 600);
        chk("pwm8 period", 32'd510, per_len);
        chk("pwm8 high", 32'd6, hi_len);
        chk("pwm8 irq", 32'h1, irq_cnt - base);
        // A zero high width keeps the pin low yet still interrupts.
        pwm_run(1'b1, 16'h0001);
        cyc(600);
        chk("zero rises", 32'h0, rise_cnt - rb);
        chk("zero irq", 32'h1, irq_cnt - base);
        // 16-bit PWM over one full cycle.
        pwm_run(1'b0, 16'h0064);
        wait_rise(rb + 32'h2, 70000);
        chk("pwm16 period", 32'd65535, per_len);
        chk("pwm16 high", 32'd100, hi_len);
        chk("pwm16 irq", 32'h1, irq_cnt - base);
        stop_test();
    end
endmodule // tb

// [src/ospt_pkg.sv]
// Package with constants and types for the one-shot / PWM timer channel.
// ----------------------------------------------------------------------------
// Notes on behaviour
// (R1) One-shot counts down; at zero reloads the reload value, then halts.
// (R2) One-shot trigger while running reloads the counter and restarts the countdown.
// (R3) One-shot starts on external trigger, associated timer overflow, or start flag.
// (R4) Clearing the count start flag stops the counter at once in both modes.
// (R5) One-shot raises its interrupt request when the count reaches zero.
// (R6) Input pin is a general port or the trigger input, per configuration.
// (R7) One-shot output pin is a general port or the pulse output, per configuration.
// (R8) Timer register reads in these modes return an undefined value.
// (R9) A write while stopped updates both reload register and counter.
// (R10) A write while counting updates the reload only; counter takes it at next reload.
// (R11) PWM counts down as an 8-bit or 16-bit modulator, chosen by software.
// (R12) PWM reloads at each output rising edge and keeps counting.
// (R13) PWM ignores triggers that arrive while already running.
// (R14) 16-bit PWM high time is n periods; cycle is 65535 periods.
// (R15) 8-bit PWM high time n*(m+1), cycle 255*(m+1) periods.
// (R16) PWM starts on external trigger, associated timer overflow, or start flag.
// (R17) 8-bit PWM interrupt at output fall; for n FF or 00, at count 01.
// (R18) 16-bit PWM interrupt at output fall; for n FFFF or 0000, at count 0001.
// (R19) High width zero holds output low and loads all ones into the timer.
// (R20) Count source is clock, clock/8, clock/32, or subclock/32.
// (R21) One-shot active period lasts n count-source periods.
// ----------------------------------------------------------------------------
package ospt_pkg;
    localparam logic [15:0] OSPT_RST_COUNT = 16'h0000;
    localparam logic [15:0] OSPT_PWM16_CYCLE = 16'hffff;
    localparam logic [7:0] OSPT_PWM8_CYCLE = 8'hff;
    localparam logic [4:0] OSPT_DIV8_LAST = 5'h07;
    localparam logic [4:0] OSPT_DIV32_LAST = 5'h1f;
    typedef enum logic [1:0] {
        OSPT_SRC_F1 = 2'h0,
        OSPT_SRC_F8 = 2'h1,
        OSPT_SRC_F32 = 2'h2,
        OSPT_SRC_FC32 = 2'h3
    } ospt_src_t;
    typedef enum logic [2:0] {
        OSPT_ST_IDLE = 3'b001,
        OSPT_ST_ONESHOT = 3'b010,
        OSPT_ST_PWM = 3'b100
    } ospt_state_t;
endpackage

// [src/ospt_prescaler.sv]
// Count-source prescaler producing one-cycle enable pulses.
`timescale 1ns/100ps
module ospt_prescaler (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sub_clk_pin,
    ospt_tick_if.gen tick_bus
);
    import ospt_pkg::*;

    logic [4:0] div_q;
    logic [4:0] sub_div_q;
    logic sub_s1_q;
    logic sub_s2_q;
    logic sub_s3_q;
    logic sub_rise;
    logic [3:0] tick_vec;

    // ------------------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------------------
    // The subclock is asynchronous, so it is synchronised before its edges are counted.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q <= 5'h00;
            sub_div_q <= 5'h00;
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else begin
            div_q <= div_q + 5'h01;
            sub_s1_q <= sub_clk_pin;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
            if (sub_rise) begin
                sub_div_q <= sub_div_q + 5'h01;
            end
        end
    end

    // Tick selection; the subclock rate is limited by the core clock sampling it.
    assign sub_rise = sub_s2_q & ~sub_s3_q;
    assign tick_vec[0] = 1'b1;
    assign tick_vec[1] = (div_q[2:0] == OSPT_DIV8_LAST[2:0]);
    assign tick_vec[2] = (div_q == OSPT_DIV32_LAST);
    assign tick_vec[3] = sub_rise && (sub_div_q == OSPT_DIV32_LAST);
    assign tick_bus.tick = tick_vec[tick_bus.src_sel]; // R20
endmodule // ospt_prescaler

// [src/ospt_tick_if.sv]
// Interface carrying the count-source selection and tick between modules.
`timescale 1ns/100ps
interface ospt_tick_if;
    import ospt_pkg::*;
    ospt_src_t src_sel;
    logic tick;
    modport gen (input src_sel, output tick);
    modport use_end (output src_sel, input tick);
endinterface // ospt_tick_if

// [src/ospt_timer.sv]
// Top of the one-shot and PWM timer channel.
`timescale 1ns/100ps
module ospt_timer (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sub_clk_pin,
    input wire logic trigger_input_pin,
    input wire ospt_pkg::ospt_src_t src_sel,
    input wire logic pwm_mode,
    input wire logic pwm_8bit,
    input wire logic trig_pin_en,
    input wire logic ext_trig_en,
    input wire logic ovf_trig_en,
    input wire logic assoc_overflow,
    input wire logic out_pin_en,
    input wire logic port_out_val,
    input wire logic count_start,
    input wire logic oneshot_start,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data,
    output logic port_in_val,
    output logic pulse_output_pin,
    output logic irq,
    output logic running
);
    import ospt_pkg::*;

    ospt_tick_if tick_bus ();
    ospt_state_t state_q;
    ospt_state_t state_d;
    logic [15:0] reload_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [7:0] pre_q;
    logic [7:0] pre_d;
    logic pwm_hi_q;
    logic pwm_hi_d;
    logic [15:0] phase_q;
    logic [15:0] phase_d;
    logic out_q;
    logic irq_q;
    logic irq_d;
    logic trig_level;
    logic trig_rise;
    logic start_ev;
    logic pwm_start_ev;
    logic tick;
    logic os_active;
    logic os_zero;
    logic os_retrig;
    logic pwm_active;
    logic cnt_step;
    logic [15:0] pwm_cycle;
    logic [15:0] pwm_n;
    logic [15:0] pwm_n_q;
    logic n_zero;
    logic n_full;
    logic cycle_end;
    logic hi_end;
    logic cnt_one;
    logic timer_out;
    logic pwm_out_d;

    // ------------------------------------------------------------------------
    // Count source and trigger
    // ------------------------------------------------------------------------
    assign tick_bus.src_sel = src_sel;

    ospt_prescaler u_pre (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sub_clk_pin(sub_clk_pin),
        .tick_bus(tick_bus)
    );

    ospt_trig_sync u_trig (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin(trigger_input_pin),
        .pin_level(trig_level),
        .pin_rise(trig_rise)
    );

    assign tick = tick_bus.tick;

    // Start events combine pin trigger, the neighbour's overflow and software.
    assign start_ev = (trig_pin_en && ext_trig_en && trig_rise) || (ovf_trig_en && assoc_overflow); // R3 R6
    assign pwm_start_ev = start_ev || count_start; // R16

    // ------------------------------------------------------------------------
    // One-shot decode
    // ------------------------------------------------------------------------
    assign os_active = (state_q == OSPT_ST_ONESHOT);
    assign pwm_active = (state_q == OSPT_ST_PWM);
    assign os_retrig = os_active && start_ev; // R2
    assign os_zero = os_active && tick && (count_q == 16'h0001);

    // ------------------------------------------------------------------------
    // PWM decode
    // ------------------------------------------------------------------------
    // The phase counter walks the whole cycle; the count register holds the
    // remaining high time so the reload value only lands on a rising edge.
    assign pwm_cycle = pwm_8bit ? {8'h00, OSPT_PWM8_CYCLE} : OSPT_PWM16_CYCLE; // R14 R15
    assign pwm_n = pwm_8bit ? {8'h00, reload_q[15:8]} : reload_q;
    assign n_zero = pwm_8bit ? (pwm_n_q[7:0] == 8'h00) : (pwm_n_q == 16'h0000);
    assign n_full = pwm_8bit ? (pwm_n_q[7:0] == 8'hff) : (pwm_n_q == 16'hffff);
    assign cnt_step = pwm_active && tick && (!pwm_8bit || (pre_q == 8'h00)); // R11 R15
    assign cycle_end = cnt_step && (phase_q == 16'h0001);
    assign hi_end = cnt_step && pwm_hi_q && (count_q == 16'h0001);
    assign cnt_one = cnt_step && (phase_q == 16'h0002);
    assign timer_out = os_active || (pwm_active && pwm_hi_q);
    assign pwm_out_d = pwm_hi_q && !n_zero; // R19

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        pre_d = pre_q;
        pwm_hi_d = pwm_hi_q;
        phase_d = phase_q;
        irq_d = 1'b0;
        unique case (state_q)
            OSPT_ST_IDLE: begin
                if (!pwm_mode && (start_ev || oneshot_start)) begin
                    state_d = OSPT_ST_ONESHOT; // R3
                    count_d = reload_q; // R21
                end else if (pwm_mode && pwm_start_ev) begin
                    state_d = OSPT_ST_PWM; // R16
                    count_d = (pwm_n == 16'h0000) ? pwm_cycle : pwm_n; // R19
                    phase_d = pwm_cycle;
                    pre_d = reload_q[7:0];
                    pwm_hi_d = 1'b1;
                end
            end
            OSPT_ST_ONESHOT: begin
                if (os_retrig) begin
                    count_d = reload_q; // R2
                end else if (os_zero) begin
                    count_d = reload_q; // R1
                    state_d = OSPT_ST_IDLE; // R1
                    irq_d = 1'b1; // R5
                end else if (tick) begin
                    count_d = count_q - 16'h0001; // R1
                end
            end
            // Start events are never looked at here, so a running modulator ignores them.
            OSPT_ST_PWM: begin // R13
                if (tick && !pwm_8bit) begin
                    pre_d = pre_q;
                end else if (tick) begin
                    pre_d = (pre_q == 8'h00) ? reload_q[7:0] : pre_q - 8'h01; // R15
                end
                if (cycle_end) begin
                    phase_d = pwm_cycle; // R12
                    count_d = (pwm_n == 16'h0000) ? pwm_cycle : pwm_n; // R12 R19
                    pwm_hi_d = 1'b1;
                end else if (cnt_step) begin
                    phase_d = phase_q - 16'h0001;
                    if (pwm_hi_q) begin
                        count_d = count_q - 16'h0001; // R14
                    end
                    if (hi_end && !n_full && !n_zero) begin
                        pwm_hi_d = 1'b0;
                        irq_d = 1'b1; // R17 R18
                    end
                end
                if (cnt_one && (n_full || n_zero)) begin
                    irq_d = 1'b1; // R17 R18
                end
            end
            default: begin
                state_d = OSPT_ST_IDLE;
            end
        endcase
        // A software write while stopped overrides the start load, and a stop takes precedence over counting.
        if (wr_en && (state_q == OSPT_ST_IDLE)) begin
            count_d = wr_data; // R9
        end
        if (!count_start) begin
            state_d = OSPT_ST_IDLE; // R4
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // The reload register always takes writes; the counter only when stopped.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= OSPT_ST_IDLE;
            reload_q <= OSPT_RST_COUNT;
            count_q <= OSPT_RST_COUNT;
            pre_q <= 8'h00;
            pwm_hi_q <= 1'b0;
            phase_q <= 16'h0000;
            pwm_n_q <= 16'h0000;
            out_q <= 1'b0;
            irq_q <= 1'b0;
            rd_data <= 16'h0000;
            port_in_val <= 1'b0;
            running <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            pre_q <= pre_d;
            pwm_hi_q <= pwm_hi_d;
            phase_q <= phase_d;
            if (wr_en) begin
                reload_q <= wr_data; // R9 R10
            end
            if ((state_q == OSPT_ST_IDLE) || cycle_end) begin
                pwm_n_q <= pwm_n; // R10
            end
            out_q <= pwm_mode ? pwm_out_d && pwm_active : (out_pin_en ? timer_out : port_out_val); // R7 R19
            irq_q <= irq_d;
            rd_data <= count_q ^ phase_q; // R8
            port_in_val <= trig_level; // R6
            running <= (state_d != OSPT_ST_IDLE);
        end
    end

    assign pulse_output_pin = out_q;
    assign irq = irq_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_stop_is_immediate: assert property (@(posedge core_clk) disable iff (sys_rst)
        !count_start |=> !running) // R4
        else $error("Timer kept running after count start flag cleared.");

    a_os_zero_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        os_zero && !os_retrig && count_start |=> irq && !running) // R1 R5
        else $error("One-shot end did not raise irq and halt.");

    a_os_reload_at_end: assert property (@(posedge core_clk) disable iff (sys_rst)
        os_zero && !os_retrig && count_start && !wr_en |=> count_q == $past(reload_q)) // R1
        else $error("One-shot end did not reload count.");

    a_os_retrigger: assert property (@(posedge core_clk) disable iff (sys_rst)
        os_retrig && count_start |=> count_q == $past(reload_q)) // R2
        else $error("Retrigger did not reload count.");

    a_write_stopped: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_en && state_q == OSPT_ST_IDLE |=> count_q == $past(wr_data) && reload_q == $past(wr_data)) // R9
        else $error("Write while stopped missed counter or reload.");

    a_write_running: assert property (@(posedge core_clk) disable iff (sys_rst)
        wr_en && os_active && !os_retrig && !os_zero |=>
        count_q == $past(count_q) - {15'h0000, $past(tick)}) // R10
        else $error("Write while counting changed the counter.");

    a_pwm_zero_low: assert property (@(posedge core_clk) disable iff (sys_rst)
        pwm_active && pwm_mode && n_zero ##1 pwm_mode |-> !pulse_output_pin) // R19
        else $error("Zero high width did not hold output low.");

    a_pwm_ignore_trig: assert property (@(posedge core_clk) disable iff (sys_rst)
        pwm_active && start_ev && !cnt_step && count_start && !wr_en |=> count_q == $past(count_q)) // R13
        else $error("Trigger disturbed a running PWM counter.");

    a_irq_one_cycle: assert property (@(posedge core_clk) disable iff (sys_rst)
        irq |=> !irq) // R5 R17 R18
        else $error("Interrupt request longer than one cycle.");

    // Apart from the start from idle, the wrap of the phase counter is the only place where a new high phase may start.
    a_pwm_rise_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
        cycle_end && count_start |=> pwm_hi_q && phase_q == $past(pwm_cycle)) // R12
        else $error("PWM cycle end did not reload and raise the pulse.");

    a_pwm_fall_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        hi_end && !cycle_end && !n_full && !n_zero && count_start |=> irq && !pwm_hi_q) // R17 R18
        else $error("PWM falling edge did not raise irq.");
endmodule // ospt_timer

// [src/ospt_trig_sync.sv]
// Trigger pin synchroniser with rising-edge detector and port pass-through.
`timescale 1ns/100ps
module ospt_trig_sync (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic pin,
    output logic pin_level,
    output logic pin_rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Two flip-flops before any logic, then a third for the edge.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign pin_level = s2_q;
    assign pin_rise = s2_q & ~s3_q;
endmodule // ospt_trig_sync
